/* File: src/scma_pkg.sv */
// Purpose: constants and types for the connection memory access block
// Assumes: 16-bit register port, 20 MHz system clock
// Notes:   offsets are byte addresses on the register port
package scma_pkg;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0]  ADDR_ACCESS_CTRL  = 8'h10;
	localparam logic [7:0]  ADDR_FAULT_TALLY  = 8'h12;
	localparam logic [7:0]  ADDR_CONN_DATA    = 8'h20;
	localparam logic [7:0]  ADDR_DATA_MEM     = 8'h22;
	localparam logic [7:0]  ADDR_CONFIG       = 8'h24;
	localparam logic [15:0] RST_ACCESS_CTRL   = 16'h0800;
	localparam logic [15:0] RST_FAULT_TALLY   = 16'h0000;
	localparam logic [15:0] ACCESS_WR_MASK    = 16'h3fff;
	localparam logic [15:0] TALLY_FULL        = 16'hffff;
	localparam logic [15:0] ZERO16            = 16'h0000;
	// ----------------------------------------
	// field positions of the access register
	// ----------------------------------------
	localparam int BIT_READ       = 8;
	localparam int BIT_MEM_SEL    = 9;
	localparam int BIT_BIDIR      = 10;
	localparam int BIT_FULL_SWEEP = 11;
	localparam int BIT_LIM_SWEEP  = 12;
	localparam int BIT_TRANSP     = 13;
	localparam int BIT_MUX_LSB    = 5;
	// config register bits
	localparam int CFG_PRBS_EN    = 0;
	localparam int CFG_FAST_CLK   = 1;
	localparam int CFG_SWRESET    = 2;
	localparam int CFG_LANE4_LSB  = 4;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_MHZ          = 20;
	localparam int INIT_LIMIT_US    = 250;
	localparam int INIT_LIMIT_CYC   = INIT_LIMIT_US * CLK_MHZ;
	localparam logic [8:0] LAST_LOC = 9'h0ff;
	localparam logic [4:0] LAST_SLOT = 5'h1f;

	typedef enum logic [4:0]
	{
		ST_INIT  = 5'b00001,
		ST_IDLE  = 5'b00010,
		ST_WRITE = 5'b00100,
		ST_REV   = 5'b01000,
		ST_SWEEP = 5'b10000
	} scma_state_e;

	typedef struct packed
	{
		logic [7:0] addr;
		logic [15:0] wdata;
		logic       wr;
		logic       rd;
	} scma_bus_s;

	typedef struct packed
	{
		logic [1:0] lane;
		logic [5:0] slot;
	} scma_fast_loc_s;
endpackage : scma_pkg

/* File: src/scma_top.sv */
// Purpose: host access to the connection and data memories, fault tally
// Assumes: synchronous inputs, register port read data one cycle later
// Notes:   connection memory is 256 words of 16 bits in flip-flops
`timescale 1ns/10ps
// How it works
// - an access starts only on a write of the destination byte.
// - memory select picks connection memory; otherwise only data memory reads.
// - five slot bits and three mux bits address slot 0-31, mux 0-7.
// - at 4 Mbit/s mux bits 7:6 choose output lane 0,2,4,6.
// - at 4 Mbit/s output slot is slot bits with bit 5 as LSB.
// - at 4 Mbit/s source bits decode input lane and slot 0-63 alike.
// - bit 5 means odd multiplex at 2 Mb/s, odd slot at 4 Mb/s.
// - fast clock samples at 3/4; slow clock at half for 4 Mbit/s.
// - read bit set reads memory; clear writes connection memory.
// - after reset a sequencer clears memory; host stops it with 0200H.
// - init sequencer zeroes all locations until a write with full sweep clear.
// - bidirectional write adds reverse connection without loopback.
// - full sweep write copies data from destination up to location FF.
// - full sweep read loads next location after each data read.
// - limited sweep covers the selected mux up to slot 1F.
// - transparent write uses destination as source too.
// - fault tally clears on host read.
// - tally counts faults only while checker enabled and synchronised.
// - tally saturates at all ones.
// - full flag set when the tally reaches all ones.
module scma_top
	import scma_pkg::*;
(
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        nrst,
	// register port
	input  wire scma_bus_s   bus,
	output logic [15:0]      rdata,
	// data memory read port
	output logic [7:0]       dmem_addr,
	input  wire logic [7:0]  dmem_rdata,
	// prbs checker
	input  wire logic        prbs_synced,
	input  wire logic        prbs_fault,
	// status and decode
	output logic             fault_tally_full_flag,
	output logic             init_busy,
	output logic [2:0]       out_lane,
	output logic [5:0]       out_slot_fast,
	output logic [2:0]       in_lane,
	output logic [5:0]       in_slot_fast,
	output logic [1:0]       sample_phase
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	scma_state_e   state,      next_state;
	logic [15:0]   acc,        next_acc;
	logic [15:0]   cdata,      next_cdata;
	logic [15:0]   tally,      next_tally;
	logic [7:0]    cfg,        next_cfg;
	logic          full_flag,  next_full_flag;
	logic [8:0]    ptr,        next_ptr;
	logic [15:0]   rdq,        next_rdq;
	logic          sweep_rd,   next_sweep_rd;
	logic [15:0]   cmem [256];
	logic          mem_we;
	logic [7:0]    mem_wa;
	logic [15:0]   mem_wd;

	function automatic logic [15:0] make_entry(input logic [15:0] d, input logic [7:0] src,
		input logic drop_loop);
		logic [15:0] e;
		e = {d[15:8], src};
		if (drop_loop)
			e[15] = 1'b0;
		return e;
	endfunction : make_entry

	function automatic scma_fast_loc_s fast_loc(input logic [7:0] f);
		scma_fast_loc_s l;
		l.lane = f[7:6];
		l.slot = {f[4:0], f[BIT_MUX_LSB]};
		return l;
	endfunction : fast_loc

	logic dst_wr, data_rd, cfg_wr;
	assign dst_wr  = bus.wr && bus.addr == ADDR_ACCESS_CTRL;
	assign data_rd = bus.rd && bus.addr == ADDR_CONN_DATA;
	assign cfg_wr  = bus.wr && bus.addr == ADDR_CONFIG;

	// ----------------------------------------
	// access sequencer
	// ----------------------------------------
	always_comb
	begin
		next_state     = state;
		next_acc       = acc;
		next_cdata     = cdata;
		next_cfg       = cfg;
		next_ptr       = ptr;
		next_sweep_rd  = sweep_rd;
		mem_we         = 1'b0;
		mem_wa         = ptr[7:0];
		mem_wd         = ZERO16;
		if (bus.wr && bus.addr == ADDR_CONN_DATA)
			next_cdata = bus.wdata;
		if (cfg_wr)
			next_cfg = bus.wdata[7:0];
		case (state)
			ST_INIT:
			begin
				mem_we   = 1'b1;
				next_ptr = {1'b0, ptr[7:0] + 8'h01};
				if (dst_wr && !bus.wdata[BIT_FULL_SWEEP])
				begin
					next_acc   = bus.wdata & ACCESS_WR_MASK;
					next_state = ST_IDLE;
				end
			end
			ST_IDLE:
			begin
				if (cfg_wr && bus.wdata[CFG_SWRESET])
				begin
					next_ptr   = 9'h000;
					next_state = ST_INIT;
				end
				else if (dst_wr)
				begin
					next_acc      = bus.wdata & ACCESS_WR_MASK;
					next_ptr      = {1'b0, bus.wdata[7:0]};
					next_sweep_rd = 1'b0;
					if (bus.wdata[BIT_READ])
					begin
						if (bus.wdata[BIT_MEM_SEL])
						begin
							next_cdata = cmem[bus.wdata[7:0]];
							next_sweep_rd = bus.wdata[BIT_FULL_SWEEP] ||
								bus.wdata[BIT_LIM_SWEEP];
						end
						else
							next_cdata = {8'h00, dmem_rdata};
					end
					else if (bus.wdata[BIT_MEM_SEL])
						next_state = ST_WRITE;
				end
				else if (data_rd && sweep_rd)
				begin
					next_ptr = ptr + 9'h001;
					if ((acc[BIT_LIM_SWEEP] && ptr[4:0] == LAST_SLOT) || ptr[7:0] == LAST_LOC[7:0])
						next_sweep_rd = 1'b0;
					else
						next_cdata = cmem[ptr[7:0] + 8'h01];
				end
			end
			ST_WRITE:
			begin
				mem_we = 1'b1;
				if (acc[BIT_TRANSP])
					mem_wd = make_entry(cdata, ptr[7:0], 1'b0);
				else
					mem_wd = cdata;
				if (acc[BIT_FULL_SWEEP] || acc[BIT_LIM_SWEEP])
					next_state = ST_SWEEP;
				else if (acc[BIT_BIDIR] && !acc[BIT_TRANSP])
					next_state = ST_REV;
				else
					next_state = ST_IDLE;
			end
			ST_REV:
			begin
				mem_we     = 1'b1;
				mem_wa     = cdata[7:0];
				mem_wd     = make_entry(cdata, acc[7:0], 1'b1);
				next_state = ST_IDLE;
			end
			ST_SWEEP:
			begin
				if ((acc[BIT_LIM_SWEEP] && ptr[4:0] == LAST_SLOT) || ptr[7:0] == LAST_LOC[7:0])
					next_state = ST_IDLE;
				else
				begin
					next_ptr   = ptr + 9'h001;
					next_state = ST_WRITE;
				end
			end
			default:
				next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			state    <= ST_INIT;
			acc      <= RST_ACCESS_CTRL;
			cdata    <= ZERO16;
			cfg      <= 8'h00;
			ptr      <= 9'h000;
			sweep_rd <= 1'b0;
		end
		else
		begin
			state    <= next_state;
			acc      <= next_acc;
			cdata    <= next_cdata;
			cfg      <= next_cfg;
			ptr      <= next_ptr;
			sweep_rd <= next_sweep_rd;
		end
	end

	// ----------------------------------------
	// connection memory
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 256; gi++)
		begin : g_cm
			always_ff @(posedge clk_sys or negedge nrst)
			begin
				if (!nrst)
					cmem[gi] <= ZERO16;
				else if (mem_we && mem_wa == 8'(gi))
					cmem[gi] <= mem_wd;
			end
		end
	endgenerate

	// ----------------------------------------
	// fault tally
	// ----------------------------------------
	always_comb
	begin
		next_tally     = tally;
		next_full_flag = full_flag;
		if (prbs_fault && cfg[CFG_PRBS_EN] && prbs_synced && tally != TALLY_FULL)
			next_tally = tally + 16'h0001;
		if (bus.rd && bus.addr == ADDR_FAULT_TALLY)
			next_tally = ZERO16;
		if (bus.wr && bus.addr == ADDR_FAULT_TALLY)
			next_tally = bus.wdata;
		if (bus.rd && bus.addr == ADDR_CONFIG)
			next_full_flag = 1'b0;
		if (next_tally == TALLY_FULL)
			next_full_flag = 1'b1;
	end

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			tally     <= RST_FAULT_TALLY;
			full_flag <= 1'b0;
		end
		else
		begin
			tally     <= next_tally;
			full_flag <= next_full_flag;
		end
	end

	// ----------------------------------------
	// read port
	// ----------------------------------------
	always_comb
	begin
		next_rdq = ZERO16;
		if (bus.rd)
		begin
			case (bus.addr)
				ADDR_ACCESS_CTRL: next_rdq = acc & ACCESS_WR_MASK;
				ADDR_FAULT_TALLY: next_rdq = tally;
				ADDR_CONN_DATA:   next_rdq = cdata;
				ADDR_DATA_MEM:    next_rdq = {8'h00, dmem_rdata};
				ADDR_CONFIG:      next_rdq = {6'h00, full_flag, state == ST_INIT, cfg};
				default:          next_rdq = ZERO16;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			rdq <= ZERO16;
		else
			rdq <= next_rdq;
	end

	// ----------------------------------------
	// decode outputs
	// ----------------------------------------
	scma_fast_loc_s dloc, sloc;
	logic           fast_dst, fast_src;
	always_comb
	begin
		dloc = fast_loc(acc[7:0]);
		sloc = fast_loc(cdata[7:0]);
		fast_dst = cfg[CFG_LANE4_LSB + {1'b0, acc[7:6]}];
		fast_src = cfg[CFG_LANE4_LSB + {1'b0, cdata[7:6]}];
	end

	assign rdata                 = rdq;
	assign dmem_addr             = bus.wdata[7:0];
	assign fault_tally_full_flag = full_flag;
	assign init_busy             = state == ST_INIT;
	assign out_lane      = fast_dst ? {dloc.lane, 1'b0} : acc[7:5];
	assign out_slot_fast = fast_dst ? dloc.slot : {1'b0, acc[4:0]};
	assign in_lane       = fast_src ? {sloc.lane, 1'b0} : cdata[7:5];
	assign in_slot_fast  = fast_src ? sloc.slot : {1'b0, cdata[4:0]};
	assign sample_phase  = (!cfg[CFG_FAST_CLK] && fast_dst) ? 2'd2 : 2'd3;
endmodule : scma_top

/* File: dv/scma_top_asserts.sv */
// Purpose: port checker for scma_top
// Assumes: one clock, nrst async low
// Notes:   lane config mirrored from writes
`timescale 1ns/10ps
module scma_top_asserts
	import scma_pkg::*;
(
	// clock and reset
	input wire logic        clk_sys,
	input wire logic        nrst,
	// register port
	input wire scma_bus_s   bus,
	input wire logic [15:0] rdata,
	// status and decode
	input wire logic        prbs_fault,
	input wire logic        init_busy,
	input wire logic [2:0]  out_lane,
	input wire logic [5:0]  out_slot_fast,
	input wire logic [2:0]  in_lane,
	input wire logic [5:0]  in_slot_fast,
	input wire logic [1:0]  sample_phase
);
	logic [7:0] cfg_q;
	logic       tally_rd, acc_rd, stop_wr, out4_wr, in4_wr;
	assign tally_rd = bus.rd && bus.addr == ADDR_FAULT_TALLY && !prbs_fault;
	assign acc_rd   = bus.rd && bus.addr == ADDR_ACCESS_CTRL;
	assign stop_wr  = bus.wr && bus.addr == ADDR_ACCESS_CTRL && !bus.wdata[BIT_FULL_SWEEP];
	assign out4_wr  = bus.wr && bus.addr == ADDR_ACCESS_CTRL && !init_busy
		&& cfg_q[CFG_LANE4_LSB + bus.wdata[7:6]];
	assign in4_wr   = bus.wr && bus.addr == ADDR_CONN_DATA && cfg_q[CFG_LANE4_LSB + bus.wdata[7:6]];
	// mirror of the lane speed config
	always_ff @(posedge clk_sys or negedge nrst)
		if (!nrst)
			cfg_q <= 8'h00;
		else if (bus.wr && bus.addr == ADDR_CONFIG)
			cfg_q <= bus.wdata[7:0];
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	tally_clear_a: assert property (tally_rd ##1 (!prbs_fault && !bus.wr) ##1 tally_rd
		|=> rdata == ZERO16)
		else $error("tally not cleared by read");
	top_bits_a: assert property ($past(acc_rd) |-> rdata[15:14] == 2'b00)
		else $error("access top bits not zero");
	init_hold_a: assert property ($fell(init_busy) |-> $past(stop_wr) || $past(stop_wr, 2))
		else $error("init stopped without host write");
	init_stop_a: assert property (stop_wr && init_busy |-> ##[1:2] !init_busy)
		else $error("init not stopped");
	fast_phase_a: assert property (bus.wr && bus.addr == ADDR_CONFIG && bus.wdata[CFG_FAST_CLK]
		|=> sample_phase == 2'd3)
		else $error("fast clock phase wrong");
	out_lane_a: assert property (out4_wr |=> out_lane == {$past(bus.wdata[7:6]), 1'b0})
		else $error("output lane decode wrong");
	out_slot_a: assert property (out4_wr
		|=> out_slot_fast == {$past(bus.wdata[4:0]), $past(bus.wdata[BIT_MUX_LSB])})
		else $error("output slot decode wrong");
	in_loc_a: assert property (in4_wr |=> in_lane == {$past(bus.wdata[7:6]), 1'b0}
		&& in_slot_fast == {$past(bus.wdata[4:0]), $past(bus.wdata[BIT_MUX_LSB])})
		else $error("input location decode wrong");
	cover property (stop_wr && init_busy);
	cover property (tally_rd ##2 tally_rd);
	cover property (out4_wr);
endmodule : scma_top_asserts
bind scma_top scma_top_asserts scma_top_asserts_i (.clk_sys, .nrst, .bus, .rdata, .prbs_fault,
	.init_busy, .out_lane, .out_slot_fast, .in_lane, .in_slot_fast, .sample_phase);

/* File: dv/scma_far_end.sv */
// Purpose: data memory and sequence checker model
// Assumes: faults requested by the bench
// Notes:   memory byte is the inverse of its address
`timescale 1ns/10ps
module scma_far_end
	import scma_pkg::*;
(
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       nrst,
	// data memory
	input  wire logic [7:0] dmem_addr,
	output logic [7:0]      dmem_rdata,
	// sequence checker
	input  wire logic       sync_req,
	input  wire logic       fault_req,
	output logic            prbs_synced,
	output logic            prbs_fault
);
	assign dmem_rdata = ~dmem_addr;
	always_ff @(posedge clk_sys or negedge nrst)
		if (!nrst)
		begin
			prbs_synced <= 1'b0;
			prbs_fault  <= 1'b0;
		end
		else
		begin
			prbs_synced <= sync_req;
			prbs_fault  <= fault_req;
		end
endmodule : scma_far_end

/* File: dv/tb_switch_connection_memory_access.sv */
// Purpose: self-checking bench for scma_top
// Assumes: 20 MHz clock, reset 12 cycles
// Notes:   one task per scenario
`timescale 1ns/10ps
module tb_switch_connection_memory_access
	import scma_pkg::*;
();
	logic        clk_sys, nrst, sync_req, fault_req, prbs_synced, prbs_fault;
	logic        fault_tally_full_flag, init_busy;
	scma_bus_s   bus;
	logic [15:0] rdata;
	logic [7:0]  dmem_addr, dmem_rdata;
	logic [2:0]  out_lane, in_lane;
	logic [5:0]  out_slot_fast, in_slot_fast;
	logic [1:0]  sample_phase;
	int          n_fail, checks;
	scma_top scma_top_i (.clk_sys, .nrst, .bus, .rdata, .dmem_addr, .dmem_rdata, .prbs_synced,
		.prbs_fault, .fault_tally_full_flag, .init_busy, .out_lane, .out_slot_fast, .in_lane,
		.in_slot_fast, .sample_phase);
	scma_far_end scma_far_end_i (.clk_sys, .nrst, .dmem_addr, .dmem_rdata, .sync_req,
		.fault_req, .prbs_synced, .prbs_fault);
	initial
	begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	task automatic wrap_up;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : tick
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_sys);
		bus.wr <= 1'b0;
		tick(2);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		@(posedge clk_sys);
		bus <= '{a, ZERO16, 1'b0, 1'b1};
		@(posedge clk_sys);
		bus.rd <= 1'b0;
		#1 chk(rdata, exp);
	endtask : rd
	task automatic faults;
		repeat (3)
		begin
			@(posedge clk_sys);
			fault_req <= 1'b1;
			@(posedge clk_sys);
			fault_req <= 1'b0;
		end
		tick(3);
	endtask : faults
	task automatic t_init;
		chk(16'(init_busy), 16'h0001);
		rd(ADDR_ACCESS_CTRL, RST_ACCESS_CTRL);
		rd(ADDR_FAULT_TALLY, RST_FAULT_TALLY);
		tick(300);
		wr(ADDR_ACCESS_CTRL, 16'h0a05);
		chk(16'(init_busy), 16'h0001);
		wr(ADDR_ACCESS_CTRL, 16'h0200);
		for (int i = 0; i < 10 && init_busy; i++)
			tick(1);
		chk(16'(init_busy), 16'h0000);
		if (init_busy !== 1'b0)
			wrap_up();
		wr(ADDR_ACCESS_CTRL, 16'h0334);
		rd(ADDR_CONN_DATA, ZERO16);
	endtask : t_init
	task automatic t_conn;
		wr(ADDR_CONN_DATA, 16'ha5c3);
		wr(ADDR_ACCESS_CTRL, 16'h0205);
		wr(ADDR_CONN_DATA, 16'h0f0f);
		wr(ADDR_ACCESS_CTRL, 16'h0005);
		wr(ADDR_ACCESS_CTRL, 16'h0305);
		rd(ADDR_CONN_DATA, 16'ha5c3);
		wr(ADDR_ACCESS_CTRL, 16'h0177);
		rd(ADDR_CONN_DATA, 16'h0088);
		rd(ADDR_DATA_MEM, 16'h00ff);
		wr(ADDR_ACCESS_CTRL, 16'hc000);
		rd(ADDR_ACCESS_CTRL, ZERO16);
	endtask : t_conn
	task automatic t_modes;
		wr(ADDR_CONN_DATA, 16'h9346);
		wr(ADDR_ACCESS_CTRL, 16'h0621);
		wr(ADDR_ACCESS_CTRL, 16'h0346);
		rd(ADDR_CONN_DATA, 16'h1321);
		wr(ADDR_CONN_DATA, 16'h4400);
		wr(ADDR_ACCESS_CTRL, 16'h2210);
		wr(ADDR_ACCESS_CTRL, 16'h0310);
		rd(ADDR_CONN_DATA, 16'h4410);
		wr(ADDR_CONN_DATA, 16'h1234);
		wr(ADDR_ACCESS_CTRL, 16'h0efc);
		tick(10);
		wr(ADDR_CONN_DATA, 16'h5555);
		wr(ADDR_ACCESS_CTRL, 16'h02fb);
		wr(ADDR_ACCESS_CTRL, 16'h0bfb);
		rd(ADDR_CONN_DATA, 16'h5555);
		repeat (4)
		begin
			tick(2);
			rd(ADDR_CONN_DATA, 16'h1234);
		end
		wr(ADDR_CONN_DATA, 16'h7777);
		wr(ADDR_ACCESS_CTRL, 16'h123e);
		tick(6);
		wr(ADDR_ACCESS_CTRL, 16'h033f);
		rd(ADDR_CONN_DATA, 16'h7777);
		wr(ADDR_ACCESS_CTRL, 16'h0340);
		rd(ADDR_CONN_DATA, ZERO16);
	endtask : t_modes
	task automatic t_tally;
		wr(ADDR_CONFIG, 16'h0001);
		wr(ADDR_FAULT_TALLY, 16'hff00);
		faults();
		rd(ADDR_FAULT_TALLY, 16'hff00);
		sync_req <= 1'b1;
		wr(ADDR_FAULT_TALLY, 16'hff00);
		faults();
		rd(ADDR_FAULT_TALLY, 16'hff03);
		rd(ADDR_FAULT_TALLY, ZERO16);
		wr(ADDR_FAULT_TALLY, 16'hfffe);
		faults();
		chk(16'(fault_tally_full_flag), 16'h0001);
		rd(ADDR_FAULT_TALLY, TALLY_FULL);
	endtask : t_tally
	task automatic t_decode;
		wr(ADDR_CONFIG, 16'h00f2);
		chk(16'(sample_phase), 16'h0003);
		wr(ADDR_ACCESS_CTRL, 16'h02e7);
		chk(16'(out_lane), 16'h0006);
		chk(16'(out_slot_fast), 16'h000f);
		wr(ADDR_CONN_DATA, 16'h0065);
		chk(16'(in_lane), 16'h0002);
		chk(16'(in_slot_fast), 16'h000b);
		wr(ADDR_CONFIG, 16'h00f0);
		chk(16'(sample_phase), 16'h0002);
	endtask : t_decode
	initial
	begin
		nrst = 1'b0;
		bus = '0;
		sync_req = 1'b0;
		fault_req = 1'b0;
		tick(12);
		nrst = 1'b1;
		t_init();
		t_conn();
		t_modes();
		t_tally();
		t_decode();
		wrap_up();
	end
endmodule : tb_switch_connection_memory_access
